/* File: test/mlf_engine_tb.sv */
/*
  Self-checking bench of the learning and forwarding engine, with the MAC model as partner.
  Assumes a short aging tick so that removal shows within a few thousand cycles.
*/
`timescale 1ns/1ps
module mlf_engine_tb
  import mlf_pkg::*;
;
  localparam longint unsigned TICK = 200;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  mlf_cfg_t cfg = '{aging_en: 1'b0, jumbo_en: 1'b0, stp_fwd: 5'h1f, auth_ok: 5'h1f,
                    mirror_rx: 5'h00, sniffer_map: 5'h00};
  logic start = 1'b0;
  mlf_rx_desc_t mdesc = '0;
  logic [3:0] stall = 4'h0;
  logic rx_valid, rx_ready, fwd_valid, fwd_ready, pause_valid, done;
  mlf_rx_desc_t rx_desc;
  mlf_fwd_desc_t fwd_desc, got;
  logic [2:0] pause_port, pause_seen_port;
  logic alloc_ready = 1'b0;
  logic free_valid = 1'b0;
  logic [BW-1:0] free_idx = 9'h000;
  logic alloc_valid, free_ready;
  logic [BW-1:0] alloc_idx;
  logic [BW:0] free_cnt;
  logic [AW:0] entry_cnt;
  int fail_count = 0;
  int num_checks = 0;
  int pauses = 0;
  int cyc = 0;
  localparam logic [47:0] MA = 48'h020000000001;
  localparam logic [47:0] MB = 48'h020000000002;
  localparam logic [47:0] MC = 48'h020000000003;
  localparam logic [47:0] MD = 48'h020000000004;

  mlf_engine #(.TICK_CYC(TICK), .N_ENT(NENT)) mlf_engine_i (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_desc(rx_desc), .fwd_valid(fwd_valid),
    .fwd_ready(fwd_ready), .fwd_desc(fwd_desc), .pause_valid(pause_valid), .pause_port(pause_port),
    .buf_alloc_valid(alloc_valid), .buf_alloc_ready(alloc_ready), .buf_alloc_idx(alloc_idx),
    .buf_free_valid(free_valid), .buf_free_ready(free_ready), .buf_free_idx(free_idx),
    .buf_free_cnt(free_cnt), .entry_cnt(entry_cnt));
  mlf_mac_model mlf_mac_model_i (.sys_clk(sys_clk), .rst(rst), .start(start), .desc(mdesc),
    .stall(stall), .rx_ready(rx_ready), .fwd_valid(fwd_valid), .fwd_desc(fwd_desc),
    .rx_valid(rx_valid), .rx_desc(rx_desc), .fwd_ready(fwd_ready), .got(got), .done(done));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (pause_valid === 1'b1) begin
      pauses <= pauses + 1;
      pause_seen_port <= pause_port;
    end
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks = num_checks + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, e);
    end
  endtask : chk

  function automatic mlf_rx_desc_t mk(input logic [47:0] da, input logic [47:0] sa, input logic [2:0] p,
                                      input logic [11:0] len);
    mlf_rx_desc_t d;
    d = '0;
    d.da = da;
    d.sa = sa;
    d.src_port = p;
    d.len = len;
    d.vlan_map = 5'h1f;
    d.head_buf = 9'h0a5;
    d.nbuf = 5'h03;
    return d;
  endfunction : mk

  task automatic frame(input mlf_rx_desc_t d, input logic [4:0] em, input logic [AW:0] ec);
    int k;
    @(negedge sys_clk);
    mdesc <= d;
    start <= 1'b1;
    @(negedge sys_clk);
    start <= 1'b0;
    // Looked at on the falling edge, away from the edge that moves the engine
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge sys_clk);
    chk(k < 3000, 1'b1, "answer in time");
    chk(got.final_port_map, em, "port map");
    chk(got.head_buf, d.head_buf, "head buffer");
    chk(got.nbuf, d.nbuf, "buffer count");
    chk(got.src_port, d.src_port, "source port");
    chk(entry_cnt, ec, "entry count");
  endtask : frame

  task automatic s_reset();
    chk({rx_ready, fwd_valid, alloc_valid}, 3'b101, "idle flags");
    chk(free_ready, 1'b0, "pool full");
    chk(free_cnt, 10'h200, "free buffers");
    chk(entry_cnt, 11'h000, "empty table");
  endtask : s_reset

  task automatic s_bad();
    mlf_rx_desc_t d;
    d = mk(MD, MA, 3'h1, 12'h064);
    d.fcs_err = 1'b1;
    frame(d, 5'h00, 11'h000);
    frame(mk(MD, MA, 3'h1, 12'h03f), 5'h00, 11'h000);
    frame(mk(MD, MA, 3'h1, 12'h601), 5'h00, 11'h000);
  endtask : s_bad

  task automatic s_learn();
    cfg.jumbo_en = 1'b1;
    frame(mk(MD, MA, 3'h1, 12'h640), 5'h1d, 11'h001);
    cfg.jumbo_en = 1'b0;
    stall = 4'h3;
    frame(mk(MA, MB, 3'h2, 12'h040), 5'h02, 11'h002);
    stall = 4'h0;
    frame(mk(MA, MA, 3'h1, 12'h600), 5'h00, 11'h002);
  endtask : s_learn

  task automatic s_pause();
    int n;
    n = pauses;
    frame(mk(PAUSE_DA, MA, 3'h2, 12'h040), 5'h00, 11'h002);
    chk(pauses - n, 1, "pause pulses");
    chk(pause_seen_port, 3'h2, "pause port");
  endtask : s_pause

  task automatic s_migrate();
    frame(mk(MB, MA, 3'h3, 12'h080), 5'h04, 11'h002);
    frame(mk(MA, MB, 3'h2, 12'h080), 5'h08, 11'h002);
  endtask : s_migrate

  task automatic s_stage2();
    mlf_rx_desc_t d;
    d = mk(MD, MC, 3'h4, 12'h080);
    d.vlan_map = 5'h0f;
    cfg.stp_fwd = 5'h1e;
    frame(d, 5'h0e, 11'h003);
    cfg.stp_fwd = 5'h1f;
    cfg.mirror_rx = 5'h01;
    cfg.sniffer_map = 5'h10;
    frame(mk(MA, MC, 3'h0, 12'h080), 5'h18, 11'h003);
    cfg.mirror_rx = 5'h00;
    d = mk(MD, MC, 3'h0, 12'h080);
    d.static_hit = 1'b1;
    d.static_map = 5'h06;
    frame(d, 5'h06, 11'h003);
    cfg.auth_ok = 5'h1e;
    frame(mk(MA, MC, 3'h0, 12'h080), 5'h00, 11'h003);
    d = mk(MA, MC, 3'h0, 12'h080);
    d.acl_hit = 1'b1;
    d.acl_map = 5'h13;
    frame(d, 5'h13, 11'h003);
    cfg.auth_ok = 5'h1f;
  endtask : s_stage2

  task automatic s_aging();
    int k;
    repeat (2000) @(negedge sys_clk);
    chk(entry_cnt, 11'h003, "no aging while off");
    cfg.aging_en = 1'b1;
    // Four ticks cannot all be walked within 1500 cycles
    repeat (1500) @(negedge sys_clk);
    chk(entry_cnt, 11'h003, "early removal");
    for (k = 0; k < 9000 && entry_cnt !== 11'h000; k++) @(negedge sys_clk);
    chk(entry_cnt, 11'h000, "stale entries removed");
    cfg.aging_en = 1'b0;
  endtask : s_aging

  task automatic s_pool();
    @(negedge sys_clk);
    chk(alloc_idx, 9'h1ff, "top index");
    alloc_ready = 1'b1;
    @(negedge sys_clk);
    alloc_ready = 1'b0;
    chk(free_cnt, 10'h1ff, "count after pop");
    chk(alloc_idx, 9'h1fe, "next index");
    free_valid = 1'b1;
    free_idx = 9'h1ff;
    @(negedge sys_clk);
    free_valid = 1'b0;
    chk(free_cnt, 10'h200, "count after push");
  endtask : s_pool

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    s_reset();
    s_bad();
    s_learn();
    s_pause();
    s_migrate();
    s_stage2();
    s_aging();
    s_pool();
    // Reset mid-run must refill the pool
    alloc_ready = 1'b1;
    @(negedge sys_clk);
    alloc_ready = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    s_reset();
    print_verdict();
  end
endmodule : mlf_engine_tb

/* File: test/mlf_mac_model.sv */
/*
  Model of the per-port MACs: offers one frame descriptor at a time and takes the forward answer.
  Assumes the engine on the same core clock; this side drives on the falling edge.
*/
`timescale 1ns/1ps
module mlf_mac_model
  import mlf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire mlf_rx_desc_t desc,
  input wire logic [3:0] stall,
  input wire logic rx_ready,
  input wire logic fwd_valid,
  input wire mlf_fwd_desc_t fwd_desc,
  output logic rx_valid,
  output mlf_rx_desc_t rx_desc,
  output logic fwd_ready,
  output mlf_fwd_desc_t got,
  output logic done
);
  logic took_q;
  logic shake_q;
  logic [3:0] wait_q;
  mlf_fwd_desc_t cap_q;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      took_q <= 1'b0;
      shake_q <= 1'b0;
      cap_q <= '0;
    end else begin
      took_q <= rx_valid && rx_ready;
      shake_q <= fwd_valid && fwd_ready;
      if (fwd_valid && fwd_ready) begin
        cap_q <= fwd_desc;
      end
    end
  end

  always @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_desc <= '0;
      fwd_ready <= 1'b0;
      wait_q <= 4'h0;
      got <= '0;
      done <= 1'b0;
    end else begin
      done <= shake_q;
      if (shake_q) begin
        got <= cap_q;
      end
      if (start) begin // Offered only once the whole frame sits in buffers
        rx_valid <= 1'b1;
        rx_desc <= desc;
      end else if (took_q) begin
        rx_valid <= 1'b0;
        // Released lines must not keep a stale descriptor
        rx_desc <= ~rx_desc;
      end
      if (shake_q) begin
        fwd_ready <= 1'b0;
        wait_q <= 4'h0;
      end else if (fwd_valid && !fwd_ready) begin
        if (wait_q >= stall) begin
          fwd_ready <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : mlf_mac_model

/* File: verilog/mlf_age_timer.sv */
/*
  Aging tick generator: one pulse per tick period while aging is enabled.
  Assumes the enable comes from core-clock logic.
*/
`timescale 1ns/1ps
module mlf_age_timer
  import mlf_pkg::*;
#(
  parameter longint unsigned TICK_CYC = AGE_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic aging_en,
  output logic tick
);
  initial begin
    if (TICK_CYC < 2 || TICK_CYC > 64'h0000_0003_ffff_ffff) $error("mlf_age_timer: TICK_CYC out of range");
  end

  logic [33:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    cnt_d = '0;
    tick_d = 1'b0;
    if (aging_en) begin
      if (cnt_q == 34'(TICK_CYC - 1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 34'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

  a_aging_gated: assert property (@(posedge sys_clk) disable iff (rst)
    !aging_en |=> (cnt_q == '0) && !tick) else $error("aging advanced while disabled");
endmodule : mlf_age_timer

/* File: verilog/mlf_buf_pool.sv */
/*
  Free list of the shared frame buffer pool, one index per cycle each way.
  Assumes every returned index was previously handed out and not yet returned.
*/
`timescale 1ns/1ps
module mlf_buf_pool
  import mlf_pkg::*;
#(
  parameter int unsigned N = NBUF
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic alloc_valid,
  input wire logic alloc_ready,
  output logic [BW-1:0] alloc_idx,
  input wire logic free_valid,
  output logic free_ready,
  input wire logic [BW-1:0] free_idx,
  output logic [BW:0] free_cnt
);
  initial begin
    if (N < 2 || N > (1 << BW)) $error("mlf_buf_pool: N out of range");
  end

  logic [BW-1:0] stk_q [N];
  logic [BW:0] cnt_q, cnt_d;
  logic pop, push;

  assign alloc_valid = cnt_q != '0;
  assign free_ready = cnt_q != (BW+1)'(N);
  assign pop = alloc_valid && alloc_ready;
  assign push = free_valid && free_ready;
  assign alloc_idx = stk_q[cnt_q[BW-1:0] - BW'(1)];
  assign free_cnt = cnt_q;

  always_comb begin
    cnt_d = cnt_q;
    if (pop && !push) cnt_d = cnt_q - (BW+1)'(1);
    if (push && !pop) cnt_d = cnt_q + (BW+1)'(1);
  end

  // Pop and push together swap the top slot, so the count holds
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= (BW+1)'(N);
      for (int i = 0; i < N; i++) stk_q[i] <= BW'(i);
    end else begin
      cnt_q <= cnt_d;
      if (push) stk_q[pop ? cnt_q[BW-1:0] - BW'(1) : cnt_q[BW-1:0]] <= free_idx;
    end
  end

  a_pool_alloc_count: assert property (@(posedge sys_clk) disable iff (rst)
    pop && !push |=> cnt_q == $past(cnt_q) - 1) else $error("pool count not reduced on alloc");
endmodule : mlf_buf_pool

/* File: verilog/mlf_engine.sv */
/*
  Address learning, aging and two-stage forwarding resolution, plus the shared buffer pool.
  Assumes receive MACs hand over one descriptor per frame at its end, with side lookups filled in.
*/
`timescale 1ns/1ps
module mlf_engine
  import mlf_pkg::*;
#(
  parameter longint unsigned TICK_CYC = AGE_TICK_CYC,
  parameter int unsigned N_ENT = NENT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire mlf_cfg_t cfg,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire mlf_rx_desc_t rx_desc,
  output logic fwd_valid,
  input wire logic fwd_ready,
  output mlf_fwd_desc_t fwd_desc,
  output logic pause_valid,
  output logic [2:0] pause_port,
  output logic buf_alloc_valid,
  input wire logic buf_alloc_ready,
  output logic [BW-1:0] buf_alloc_idx,
  input wire logic buf_free_valid,
  output logic buf_free_ready,
  input wire logic [BW-1:0] buf_free_idx,
  output logic [BW:0] buf_free_cnt,
  output logic [AW:0] entry_cnt
);
  initial begin
    if (N_ENT != (1 << AW)) $error("mlf_engine: N_ENT must equal 2**AW");
  end

  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_COMMIT, S_OUT, S_AGE} mlf_state_t;

  mlf_state_t st_q, st_d;
  mlf_rx_desc_t rd_q, rd_d;
  logic [AW-1:0] idx_q, idx_d;
  logic sa_hit_q, sa_hit_d, da_hit_q, da_hit_d, free_fnd_q, free_fnd_d;
  logic [AW-1:0] sa_idx_q, sa_idx_d, free_idx_q, free_idx_d;
  logic [2:0] da_port_q, da_port_d;
  logic good_q, good_d, pause_q, pause_d, local_q, local_d;
  logic [NPORT-1:0] map_q, map_d;
  logic age_pend_q, age_pend_d;
  logic [AW:0] ecnt_q, ecnt_d;

  // Table: valid bits reset, contents need none
  logic [N_ENT-1:0] val_q, val_d;
  mlf_entry_t tbl_q [N_ENT];
  logic tbl_we;
  logic [AW-1:0] tbl_widx;
  mlf_entry_t tbl_wdata;

  logic age_tick;
  logic rx_fire, bad_now, pause_now;
  logic [11:0] max_len;
  mlf_entry_t cur;
  logic cur_val;
  logic [NPORT-1:0] src_bit, stage1, stage2;
  logic learnable;
  logic local_now;

  mlf_age_timer #(.TICK_CYC(TICK_CYC)) u_age (
    .sys_clk(sys_clk),
    .rst(rst),
    .aging_en(cfg.aging_en),
    .tick(age_tick)
  );

  mlf_buf_pool #(.N(NBUF)) u_pool (
    .sys_clk(sys_clk),
    .rst(rst),
    .alloc_valid(buf_alloc_valid),
    .alloc_ready(buf_alloc_ready),
    .alloc_idx(buf_alloc_idx),
    .free_valid(buf_free_valid),
    .free_ready(buf_free_ready),
    .free_idx(buf_free_idx),
    .free_cnt(buf_free_cnt)
  );

  // Descriptor only arrives once the whole frame sits in the pool
  assign rx_ready = st_q == S_IDLE && !age_pend_q;
  assign rx_fire = rx_valid && rx_ready;
  assign max_len = cfg.jumbo_en ? LEN_MAX_BIG : LEN_MAX;
  assign bad_now = rx_desc.fcs_err || rx_desc.align_err || rx_desc.frame_err
    || rx_desc.len < LEN_MIN || rx_desc.len > max_len;
  assign pause_now = rx_desc.da == PAUSE_DA;
  assign cur = tbl_q[idx_q];
  assign cur_val = val_q[idx_q];
  assign src_bit = NPORT'(1) << rd_q.src_port;
  // Kept out of the state process so stage two has no loop through it
  assign local_now = da_hit_q && !rd_q.static_hit && da_port_q == rd_q.src_port;
  // Group source addresses are never learned
  assign learnable = good_q && !rd_q.sa[40];

  // Stage one: static entry first, then dynamic hit, else flood within VLAN
  always_comb begin
    if (rd_q.static_hit) begin
      stage1 = rd_q.static_map;
    end else if (da_hit_q) begin
      stage1 = NPORT'(1) << da_port_q;
    end else begin
      stage1 = ~src_bit;
    end
    stage1 = stage1 & rd_q.vlan_map;
  end

  // Stage two: snooping, tree state, local filter, mirror, auth, ACL last
  always_comb begin
    stage2 = stage1;
    if (rd_q.igmp_hit) stage2 = rd_q.igmp_map & rd_q.vlan_map;
    stage2 = stage2 & cfg.stp_fwd;
    if (!cfg.stp_fwd[rd_q.src_port]) stage2 = '0;
    if (local_now) stage2 = '0;
    if (cfg.mirror_rx[rd_q.src_port]) stage2 = stage2 | cfg.sniffer_map;
    stage2 = stage2 & ~src_bit;
    if (!cfg.auth_ok[rd_q.src_port]) stage2 = '0;
    if (rd_q.acl_hit) stage2 = rd_q.acl_map;
  end

  always_comb begin
    st_d = st_q;
    rd_d = rd_q;
    idx_d = idx_q;
    sa_hit_d = sa_hit_q;
    da_hit_d = da_hit_q;
    free_fnd_d = free_fnd_q;
    sa_idx_d = sa_idx_q;
    free_idx_d = free_idx_q;
    da_port_d = da_port_q;
    good_d = good_q;
    pause_d = 1'b0;
    local_d = local_q;
    map_d = map_q;
    age_pend_d = age_pend_q || age_tick;
    ecnt_d = ecnt_q;
    val_d = val_q;
    tbl_we = 1'b0;
    tbl_widx = idx_q;
    tbl_wdata = cur;
    case (st_q)
      S_IDLE: begin
        idx_d = '0;
        if (age_pend_q) begin
          st_d = S_AGE;
          age_pend_d = age_tick;
        end else if (rx_fire) begin
          rd_d = rx_desc;
          good_d = !bad_now;
          sa_hit_d = 1'b0;
          da_hit_d = 1'b0;
          free_fnd_d = 1'b0;
          local_d = 1'b0;
          if (bad_now || pause_now) begin
            // Bad and PAUSE frames skip the table entirely
            map_d = '0;
            pause_d = !bad_now && pause_now;
            st_d = S_OUT;
          end else begin
            st_d = S_SCAN;
          end
        end
      end
      // Linear scan costs N_ENT cycles per frame; traded speed for exact capacity
      S_SCAN: begin
        if (cur_val && cur.mac == rd_q.sa && !sa_hit_q) begin
          sa_hit_d = 1'b1;
          sa_idx_d = idx_q;
        end
        if (cur_val && cur.mac == rd_q.da && !da_hit_q) begin
          da_hit_d = 1'b1;
          da_port_d = cur.port;
        end
        if (!cur_val && !free_fnd_q) begin
          free_fnd_d = 1'b1;
          free_idx_d = idx_q;
        end
        idx_d = idx_q + AW'(1);
        if (idx_q == AW'(N_ENT - 1)) st_d = S_COMMIT;
      end
      S_COMMIT: begin
        local_d = local_now;
        map_d = stage2;
        st_d = S_OUT;
        if (learnable) begin
          tbl_we = 1'b1;
          tbl_wdata.mac = rd_q.sa;
          tbl_wdata.port = rd_q.src_port;
          tbl_wdata.age = 2'h0;
          if (sa_hit_q) begin
            tbl_widx = sa_idx_q;
          end else begin
            tbl_widx = free_fnd_q ? free_idx_q : AW'(N_ENT - 1);
            val_d[tbl_widx] = 1'b1;
            if (free_fnd_q) ecnt_d = ecnt_q + (AW+1)'(1);
          end
        end
      end
      S_OUT: begin
        if (fwd_ready) st_d = S_IDLE;
      end
      S_AGE: begin
        if (cur_val) begin
          tbl_we = 1'b1;
          tbl_wdata.age = cur.age + 2'h1;
          if (cur.age == AGE_LAST) begin
            val_d[idx_q] = 1'b0;
            ecnt_d = ecnt_q - (AW+1)'(1);
          end
        end
        idx_d = idx_q + AW'(1);
        if (idx_q == AW'(N_ENT - 1)) st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      rd_q <= '0;
      idx_q <= '0;
      sa_hit_q <= 1'b0;
      da_hit_q <= 1'b0;
      free_fnd_q <= 1'b0;
      sa_idx_q <= '0;
      free_idx_q <= '0;
      da_port_q <= '0;
      good_q <= 1'b0;
      pause_q <= 1'b0;
      local_q <= 1'b0;
      map_q <= '0;
      age_pend_q <= 1'b0;
      ecnt_q <= '0;
      val_q <= '0;
    end else begin
      st_q <= st_d;
      rd_q <= rd_d;
      idx_q <= idx_d;
      sa_hit_q <= sa_hit_d;
      da_hit_q <= da_hit_d;
      free_fnd_q <= free_fnd_d;
      sa_idx_q <= sa_idx_d;
      free_idx_q <= free_idx_d;
      da_port_q <= da_port_d;
      good_q <= good_d;
      pause_q <= pause_d;
      local_q <= local_d;
      map_q <= map_d;
      age_pend_q <= age_pend_d;
      ecnt_q <= ecnt_d;
      val_q <= val_d;
    end
  end

  // No reset on contents; valid bits gate every read
  always_ff @(posedge sys_clk) begin
    if (tbl_we) tbl_q[tbl_widx] <= tbl_wdata;
  end

  // Zero map tells the egress side to return the frame's buffers
  assign fwd_valid = st_q == S_OUT;
  assign fwd_desc.final_port_map = map_q;
  assign fwd_desc.src_port = rd_q.src_port;
  assign fwd_desc.head_buf = rd_q.head_buf;
  assign fwd_desc.nbuf = rd_q.nbuf;
  assign pause_valid = pause_q;
  assign pause_port = rd_q.src_port;
  assign entry_cnt = ecnt_q;

  a_bad_frame_drop: assert property (@(posedge sys_clk) disable iff (rst)
    rx_fire && bad_now |=> fwd_valid && fwd_desc.final_port_map == '0)
    else $error("bad frame not dropped");
  a_pause_consumed: assert property (@(posedge sys_clk) disable iff (rst)
    rx_fire && !bad_now && pause_now |=> pause_valid && fwd_valid && fwd_desc.final_port_map == '0)
    else $error("pause frame forwarded or not signalled");
  // A mirrored local frame may still reach the sniffer ports
  a_local_dropped: assert property (@(posedge sys_clk) disable iff (rst)
    fwd_valid && local_q && !rd_q.acl_hit && !cfg.mirror_rx[rd_q.src_port] |-> fwd_desc.final_port_map == '0)
    else $error("local frame forwarded");
  a_acl_replaces: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && rd_q.acl_hit |=> fwd_valid && fwd_desc.final_port_map == $past(rd_q.acl_map))
    else $error("ACL map not applied");
  a_fwd_holds: assert property (@(posedge sys_clk) disable iff (rst)
    fwd_valid && !fwd_ready |=> fwd_valid && fwd_desc == $past(fwd_desc))
    else $error("forward descriptor changed before taken");
  a_pause_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    pause_valid |=> !pause_valid)
    else $error("pause indication longer than one cycle");
  a_learn_writes: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && learnable && !sa_hit_q |=> val_q[$past(tbl_widx)]
    && tbl_q[$past(tbl_widx)].mac == $past(rd_q.sa) && tbl_q[$past(tbl_widx)].age == 2'h0)
    else $error("new source not learned");
  a_full_evicts_last: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && learnable && !sa_hit_q && !free_fnd_q |-> tbl_we && tbl_widx == AW'(N_ENT - 1))
    else $error("full table did not replace last entry");
  a_migrate_port: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && learnable && sa_hit_q |=> tbl_q[$past(sa_idx_q)].port == $past(rd_q.src_port))
    else $error("migration did not update port");
  a_bad_no_change: assert property (@(posedge sys_clk) disable iff (rst)
    rx_fire && bad_now |=> !tbl_we && val_q == $past(val_q))
    else $error("bad frame altered table");
  // Table writes belong to commit and aging only
  a_write_states: assert property (@(posedge sys_clk) disable iff (rst)
    tbl_we |-> st_q == S_COMMIT || st_q == S_AGE)
    else $error("table written outside commit or aging");
  a_age_remove: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_AGE && cur_val && cur.age == AGE_LAST |=> !val_q[$past(idx_q)])
    else $error("stale entry not removed");
  a_scan_length: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_IDLE && st_d == S_SCAN |=> st_q == S_SCAN [*8])
    else $error("scan ended early");

  // Every slot is visited, or capacity is no longer exact
  a_scan_steps: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_SCAN && idx_q != AW'(N_ENT - 1) |=> st_q == S_SCAN && idx_q == $past(idx_q) + AW'(1))
    else $error("scan skipped a slot");
  a_scan_ends: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_SCAN && idx_q == AW'(N_ENT - 1) |=> st_q == S_COMMIT)
    else $error("scan did not end at last slot");

  // Table contents and entry count after commit, count bound, aging start
  a_refresh_age: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && learnable && sa_hit_q |=> tbl_q[$past(sa_idx_q)].age == 2'h0)
    else $error("seen source not refreshed");
  a_evict_count: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && learnable && !sa_hit_q && !free_fnd_q |=> entry_cnt == $past(entry_cnt))
    else $error("replacing last entry changed count");
  a_learn_port: assert property (@(posedge sys_clk) disable iff (rst)
    st_q == S_COMMIT && learnable && !sa_hit_q |=> tbl_q[$past(tbl_widx)].port == $past(rd_q.src_port))
    else $error("new entry lacks receiving port");
  a_entry_bound: assert property (@(posedge sys_clk) disable iff (rst)
    entry_cnt <= (AW+1)'(N_ENT))
    else $error("entry count above capacity");
  a_age_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg.aging_en && !age_tick && !age_pend_q && st_q != S_AGE |=> st_q != S_AGE)
    else $error("aging pass started while disabled");

  c_learn_new: cover property (@(posedge sys_clk) st_q == S_COMMIT && learnable && !sa_hit_q);
  c_evict_last: cover property (@(posedge sys_clk) st_q == S_COMMIT && learnable && !sa_hit_q && !free_fnd_q);
  c_age_out: cover property (@(posedge sys_clk) st_q == S_AGE && cur_val && cur.age == AGE_LAST);
  c_forwarded: cover property (@(posedge sys_clk) fwd_valid && fwd_ready && map_q != '0);
  c_pause_seen: cover property (@(posedge sys_clk) pause_valid);
endmodule : mlf_engine

/* File: verilog/mlf_pkg.sv */
/*
  Shared constants and carrier types of the address learning and forwarding engine.
  Assumes one core clock at 100 MHz and per-port MACs on that same clock.
*/
package mlf_pkg;
  localparam int unsigned NPORT = 5;
  localparam int unsigned NENT = 1024;
  localparam int unsigned AW = 10;
  localparam int unsigned NBUF = 512;
  localparam int unsigned BUF_BYTES = 128;
  localparam int unsigned POOL_BYTES = NBUF * BUF_BYTES;
  localparam int unsigned BW = 9;
  localparam logic [11:0] LEN_MIN = 12'h040;
  localparam logic [11:0] LEN_MAX = 12'h600;
  localparam logic [11:0] LEN_MAX_BIG = 12'h800;
  localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned AGE_PERIOD_S = 300;
  localparam int unsigned AGE_TOL_S = 75;
  // Aging is judged on coarse ticks; removal lands between 225 s and 300 s
  localparam longint unsigned AGE_TICK_CYC = longint'(AGE_TOL_S) * longint'(CLK_HZ);
  localparam logic [1:0] AGE_LAST = 2'(AGE_PERIOD_S / AGE_TOL_S - 1);

  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [2:0] src_port;
    logic [11:0] len;
    logic fcs_err;
    logic align_err;
    logic frame_err;
    logic static_hit;
    logic [NPORT-1:0] static_map;
    logic [NPORT-1:0] vlan_map;
    logic igmp_hit;
    logic [NPORT-1:0] igmp_map;
    logic acl_hit;
    logic [NPORT-1:0] acl_map;
    logic [BW-1:0] head_buf;
    logic [4:0] nbuf;
  } mlf_rx_desc_t;

  typedef struct packed {
    logic aging_en;
    logic jumbo_en;
    logic [NPORT-1:0] stp_fwd;
    logic [NPORT-1:0] auth_ok;
    logic [NPORT-1:0] mirror_rx;
    logic [NPORT-1:0] sniffer_map;
  } mlf_cfg_t;

  typedef struct packed {
    logic [47:0] mac;
    logic [2:0] port;
    logic [1:0] age;
  } mlf_entry_t;

  typedef struct packed {
    logic [NPORT-1:0] final_port_map;
    logic [2:0] src_port;
    logic [BW-1:0] head_buf;
    logic [4:0] nbuf;
  } mlf_fwd_desc_t;
endpackage : mlf_pkg
